// [rtl/ssw_pkg.sv]
// constants and carrier types of the supply supervisor and watchdog
// assumes a 250 MHz core clock and a separate bus-facing clock domain
//
// Contract
// RULE1 - after power-up hold reset until supply good for the release delay
// RULE2 - low supply asserts reset; release after supply good for 200ms
// RULE3 - each start condition (data falls while clock high) restarts watchdog
// RULE4 - enabled watchdog with no start within period asserts reset
// RULE5 - host issues start conditions before the watchdog period expires
// RULE6 - two persistent period bits, host changeable unless locked
// RULE7 - period code 00 1.4s, 01 600ms, 10 200ms, 11 disabled default
// RULE8 - protect pin high and protect-enable set reject control writes
// RULE9 - reset from low supply or timeout aborts bus transaction
// RULE10 - while reset active ignore bus traffic and start no writes
// RULE11 - a nonvolatile write under way at reset runs to completion
// RULE12 - open-drain reset output, active level fixed per variant
// RULE13 - data line sensing is never gated
// RULE14 - supply flag synchronised; delays counted in clock cycles
package ssw_pkg;

    // -------------------------------------------------------------
    // timing
    // -------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS   = 4000;
    localparam int unsigned RELEASE_MS      = 200;
    localparam int unsigned WD_LONG_MS      = 1400;
    localparam int unsigned WD_MID_MS       = 600;
    localparam int unsigned WD_SHORT_MS     = 200;
    localparam longint unsigned PS_PER_MS   = 64'd1000000000;
    localparam longint unsigned RELEASE_CYC =
        (RELEASE_MS * PS_PER_MS) / CLK_PERIOD_PS;
    localparam longint unsigned WD_LONG_CYC =
        (WD_LONG_MS * PS_PER_MS) / CLK_PERIOD_PS;
    localparam longint unsigned WD_MID_CYC  =
        (WD_MID_MS * PS_PER_MS) / CLK_PERIOD_PS;
    localparam longint unsigned WD_SHORT_CYC =
        (WD_SHORT_MS * PS_PER_MS) / CLK_PERIOD_PS;
    localparam int CNT_W = 32;

    // -------------------------------------------------------------
    // period codes
    // -------------------------------------------------------------
    localparam logic [1:0] WD_CODE_LONG  = 2'h0;
    localparam logic [1:0] WD_CODE_MID   = 2'h1;
    localparam logic [1:0] WD_CODE_SHORT = 2'h2;
    localparam logic [1:0] WD_CODE_OFF   = 2'h3;
    localparam logic [1:0] WD_RESET_CODE = WD_CODE_OFF;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        SSW_HOLD,
        SSW_RUN
    } ssw_state_e;

    // config write request from the bus side
    typedef struct packed {
        logic       wdog_period_hi;
        logic       wdog_period_lo;
        logic       hw_protect_enable;
    } ssw_cfg_s;

    // per-reason reset status
    typedef struct packed {
        logic       supply_low;
        logic       wdog_expired;
    } ssw_cause_s;

endpackage : ssw_pkg

// [rtl/ssw_sync.sv]
// two-stage level synchroniser
// assumes input is asynchronous to clock
`timescale 1ns/1ps
`default_nettype none
module ssw_sync
    import ssw_pkg::*;
#(
    parameter logic RESET_VAL = 1'b0
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic arst_n,
    // data
    input  wire logic din,
    output var  logic dout
);
    logic meta;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            meta <= RESET_VAL;
            dout <= RESET_VAL;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule : ssw_sync
`default_nettype wire

// [rtl/ssw_toggle_xing.sv]
// toggle crossing for a one-cycle event between two clocks
// assumes destination clock is free running
`timescale 1ns/1ps
`default_nettype none
module ssw_toggle_xing
    import ssw_pkg::*;
(
    // source side
    input  wire logic src_clock,
    input  wire logic src_arst_n,
    input  wire logic src_pulse,
    // destination side
    input  wire logic dst_clock,
    input  wire logic dst_arst_n,
    output var  logic dst_pulse
);
    logic tog;
    logic tog_s;
    logic tog_d;

    always_ff @(posedge src_clock or negedge src_arst_n) begin
        if (!src_arst_n) begin
            tog <= 1'b0;
        end else if (src_pulse) begin
            tog <= ~tog;
        end
    end

    ssw_sync u_sync (
        .clock  (dst_clock),
        .arst_n (dst_arst_n),
        .din    (tog),
        .dout   (tog_s)
    );

    always_ff @(posedge dst_clock or negedge dst_arst_n) begin
        if (!dst_arst_n) begin
            tog_d     <= 1'b0;
            dst_pulse <= 1'b0;
        end else begin
            tog_d     <= tog_s;
            dst_pulse <= tog_s ^ tog_d;
        end
    end
endmodule : ssw_toggle_xing
`default_nettype wire

// [rtl/ssw_supervisor.sv]
// supply supervisor and start-condition watchdog
// assumes bus_clock oversamples the two-wire lines; supply flag is async
`timescale 1ns/1ps
`default_nettype none
module ssw_supervisor
    import ssw_pkg::*;
#(
    parameter longint unsigned RELEASE_CYCLES  = RELEASE_CYC,
    parameter longint unsigned WD_LONG_CYCLES  = WD_LONG_CYC,
    parameter longint unsigned WD_MID_CYCLES   = WD_MID_CYC,
    parameter longint unsigned WD_SHORT_CYCLES = WD_SHORT_CYC,
    parameter logic            ACTIVE_HIGH     = 1'b0
) (
    // core clock and reset
    input  wire logic       clock,
    input  wire logic       arst_n,
    // bus-facing clock domain
    input  wire logic       bus_clock,
    input  wire logic       bus_arst_n,
    // analog comparator, high while supply below trip
    input  wire logic       supply_low,
    // two-wire lines, sampled only
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    // write protect pin
    input  wire logic       wp_pin,
    // control write request from protocol engine, bus domain
    input  wire logic       cfg_wr,
    input  wire ssw_cfg_s   cfg_data,
    // nonvolatile write engine status, core domain
    input  wire logic       nv_busy,
    // reset pin, open drain
    output logic            rst_out,
    output logic            rst_oe,
    // bus gating, bus domain
    output logic            bus_abort,
    output logic            bus_block,
    // nonvolatile write permission and config, core domain
    output logic            nv_start_ok,
    output logic            cfg_locked,
    output logic [1:0]      wdog_period,
    output ssw_cause_s      cause
);

    // ---------------------------------------------------------------
    // synchronisers into the core domain
    // ---------------------------------------------------------------
    logic low_s;
    logic wp_s;

    ssw_sync #(.RESET_VAL(1'b1)) u_low_sync (
        .clock  (clock),
        .arst_n (arst_n),
        .din    (supply_low),
        .dout   (low_s)
    ); // RULE14

    ssw_sync u_wp_sync (
        .clock  (clock),
        .arst_n (arst_n),
        .din    (wp_pin),
        .dout   (wp_s)
    );

    // ---------------------------------------------------------------
    // bus domain: line sampling and start detection
    // ---------------------------------------------------------------
    logic scl_b;
    logic sda_b;
    logic sda_q;
    logic start_b;

    ssw_sync #(.RESET_VAL(1'b1)) u_scl_sync (
        .clock  (bus_clock),
        .arst_n (bus_arst_n),
        .din    (scl_in),
        .dout   (scl_b)
    );

    ssw_sync #(.RESET_VAL(1'b1)) u_sda_sync (
        .clock  (bus_clock),
        .arst_n (bus_arst_n),
        .din    (sda_in),
        .dout   (sda_b)
    ); // RULE13

    always_ff @(posedge bus_clock or negedge bus_arst_n) begin
        if (!bus_arst_n) begin
            sda_q   <= 1'b1;
            start_b <= 1'b0;
        end else begin
            sda_q   <= sda_b;
            start_b <= sda_q & ~sda_b & scl_b; // RULE3 RULE13
        end
    end

    // ---------------------------------------------------------------
    // crossings of events
    // ---------------------------------------------------------------
    logic start_c;
    logic cfg_wr_c;
    ssw_cfg_s cfg_hold;

    ssw_toggle_xing u_start_x (
        .src_clock  (bus_clock),
        .src_arst_n (bus_arst_n),
        .src_pulse  (start_b),
        .dst_clock  (clock),
        .dst_arst_n (arst_n),
        .dst_pulse  (start_c)
    );

    // data is held stable while its toggle crosses
    always_ff @(posedge bus_clock or negedge bus_arst_n) begin
        if (!bus_arst_n) begin
            cfg_hold <= '0;
        end else if (cfg_wr) begin
            cfg_hold <= cfg_data;
        end
    end

    ssw_toggle_xing u_cfg_x (
        .src_clock  (bus_clock),
        .src_arst_n (bus_arst_n),
        .src_pulse  (cfg_wr),
        .dst_clock  (clock),
        .dst_arst_n (arst_n),
        .dst_pulse  (cfg_wr_c)
    );

    // ---------------------------------------------------------------
    // persistent configuration
    // ---------------------------------------------------------------
    logic [1:0] period;
    logic       protect_en;
    logic       reset_act;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            period     <= WD_RESET_CODE; // RULE7
            protect_en <= 1'b0;
        end else if (cfg_wr_c && !(wp_s && protect_en) && !reset_act) begin
            period     <= {cfg_hold.wdog_period_hi,
                           cfg_hold.wdog_period_lo}; // RULE6 RULE8
            protect_en <= cfg_hold.hw_protect_enable;
        end
    end

    // ---------------------------------------------------------------
    // supply release timer
    // ---------------------------------------------------------------
    logic [CNT_W-1:0] rel_cnt;
    logic             supply_bad;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rel_cnt    <= '0;
            supply_bad <= 1'b1; // RULE1
        end else if (low_s) begin
            rel_cnt    <= '0;
            supply_bad <= 1'b1; // RULE2
        end else if (rel_cnt >= CNT_W'(RELEASE_CYCLES - 1)) begin
            supply_bad <= 1'b0; // RULE1 RULE2
        end else begin
            rel_cnt    <= rel_cnt + 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // watchdog
    // ---------------------------------------------------------------
    logic [CNT_W-1:0] wd_cnt;
    logic [CNT_W-1:0] wd_limit;
    logic             wd_fire;
    ssw_state_e       state;

    always_comb begin
        case (period)
            WD_CODE_LONG:  wd_limit = CNT_W'(WD_LONG_CYCLES - 1);
            WD_CODE_MID:   wd_limit = CNT_W'(WD_MID_CYCLES - 1);
            WD_CODE_SHORT: wd_limit = CNT_W'(WD_SHORT_CYCLES - 1);
            default:       wd_limit = '0;
        endcase
    end // RULE7

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= SSW_HOLD;
        end else begin
            case (state)
                SSW_HOLD: begin
                    if (!reset_act) begin
                        state <= SSW_RUN;
                    end
                end
                SSW_RUN: begin
                    if (reset_act) begin
                        state <= SSW_HOLD;
                    end
                end
                default: state <= SSW_HOLD;
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wd_cnt  <= '0;
            wd_fire <= 1'b0;
        end else if (start_c || period == WD_CODE_OFF
                     || state != SSW_RUN) begin
            wd_cnt  <= '0; // RULE3 RULE5
            wd_fire <= 1'b0;
        end else if (wd_cnt >= wd_limit) begin
            wd_cnt  <= '0;
            wd_fire <= 1'b1; // RULE4
        end else begin
            wd_cnt  <= wd_cnt + 1'b1;
            wd_fire <= 1'b0;
        end
    end

    // timeout reset lasts one release delay
    logic [CNT_W-1:0] wd_hold_cnt;
    logic             wd_hold;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wd_hold_cnt <= '0;
            wd_hold     <= 1'b0;
        end else if (wd_fire) begin
            wd_hold_cnt <= '0;
            wd_hold     <= 1'b1; // RULE4
        end else if (wd_hold_cnt >= CNT_W'(RELEASE_CYCLES - 1)) begin
            wd_hold     <= 1'b0;
        end else if (wd_hold) begin
            wd_hold_cnt <= wd_hold_cnt + 1'b1;
        end
    end

    assign reset_act = supply_bad | wd_hold | wd_fire;

    // ---------------------------------------------------------------
    // core outputs
    // ---------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rst_out     <= 1'b0; // RULE12
            rst_oe      <= ~ACTIVE_HIGH;
            nv_start_ok <= 1'b0;
            cfg_locked  <= 1'b0;
            wdog_period <= WD_RESET_CODE;
            cause       <= '0;
        end else begin
            // open drain: drive low only
            rst_out     <= 1'b0; // RULE12
            rst_oe      <= ACTIVE_HIGH ? ~reset_act : reset_act; // RULE12
            nv_start_ok <= ~reset_act & ~nv_busy; // RULE10 RULE11
            cfg_locked  <= wp_s & protect_en; // RULE8
            wdog_period <= period;
            cause       <= '{supply_low: supply_bad,
                             wdog_expired: wd_hold};
        end
    end

    // ---------------------------------------------------------------
    // reset level into the bus domain
    // ---------------------------------------------------------------
    logic rst_b;
    logic rst_bq;

    ssw_sync #(.RESET_VAL(1'b1)) u_rst_sync (
        .clock  (bus_clock),
        .arst_n (bus_arst_n),
        .din    (reset_act),
        .dout   (rst_b)
    );

    always_ff @(posedge bus_clock or negedge bus_arst_n) begin
        if (!bus_arst_n) begin
            rst_bq    <= 1'b1;
            bus_abort <= 1'b0;
            bus_block <= 1'b1;
        end else begin
            rst_bq    <= rst_b;
            bus_abort <= rst_b & ~rst_bq; // RULE9
            bus_block <= rst_b; // RULE10
        end
    end

endmodule : ssw_supervisor
`default_nettype wire

// [testbench/ssw_chk.sv]
// assertions on the supervisor ports
// assumes bound into ssw_supervisor
`timescale 1ns/1ps
`default_nettype none
module ssw_chk
    import ssw_pkg::*;
#(
    parameter longint unsigned RELEASE_CYCLES = 100
) (
    // clocks and resets
    input wire logic       clock,
    input wire logic       arst_n,
    input wire logic       bus_clock,
    input wire logic       bus_arst_n,
    // inputs
    input wire logic       supply_low,
    input wire logic       wp_pin,
    input wire logic       nv_busy,
    // outputs
    input wire logic       rst_out,
    input wire logic       rst_oe,
    input wire logic       bus_abort,
    input wire logic       bus_block,
    input wire logic       nv_start_ok,
    input wire logic       cfg_locked,
    input wire logic [1:0] wdog_period,
    input wire ssw_cause_s cause
);
    // ----------------------------------------------------------
    // run length of good supply
    // ----------------------------------------------------------
    longint unsigned good_cnt;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n || supply_low) begin
            good_cnt <= '0;
        end else if (good_cnt < RELEASE_CYCLES) begin
            good_cnt <= good_cnt + 1;
        end
    end
    // ----------------------------------------------------------
    // properties
    // ----------------------------------------------------------
    a_pin_drain:
        assert property (@(posedge clock) disable iff (!arst_n) !rst_out)
        else $error("reset pin driven high");
    a_low_asserts:
        assert property (@(posedge clock) disable iff (!arst_n)
            supply_low [*3] |-> ##[0:4] rst_oe)
        else $error("low supply without reset");
    a_release_wait:
        assert property (@(posedge clock) disable iff (!arst_n)
            $fell(rst_oe) |-> good_cnt >= RELEASE_CYCLES)
        else $error("reset released early");
    a_rst_no_nv:
        assert property (@(posedge clock) disable iff (!arst_n)
            rst_oe [*2] |-> !nv_start_ok)
        else $error("write start during reset");
    a_busy_no_nv:
        assert property (@(posedge clock) disable iff (!arst_n)
            nv_busy [*2] |-> !nv_start_ok)
        else $error("write start while busy");
    a_lock_needs_wp:
        assert property (@(posedge clock) disable iff (!arst_n)
            $rose(cfg_locked) |-> wp_pin)
        else $error("lock without protect pin");
    a_locked_hold:
        assert property (@(posedge clock) disable iff (!arst_n)
            cfg_locked [*8] |=> $stable(wdog_period))
        else $error("period changed while locked");
    a_default_off:
        assert property (@(posedge clock) disable iff (!arst_n)
            $rose(arst_n) |-> wdog_period == WD_CODE_OFF && cause == '0)
        else $error("bad state after reset");
    a_abort_pulse:
        assert property (@(posedge bus_clock) disable iff (!bus_arst_n)
            bus_abort |=> !bus_abort)
        else $error("abort longer than one cycle");
    a_abort_blocks:
        assert property (@(posedge bus_clock) disable iff (!bus_arst_n)
            bus_abort |-> ##[0:2] bus_block)
        else $error("abort without block");
endmodule : ssw_chk

bind ssw_supervisor ssw_chk #(.RELEASE_CYCLES(RELEASE_CYCLES)) u_ssw_chk (
    .clock, .arst_n, .bus_clock, .bus_arst_n, .supply_low, .wp_pin,
    .nv_busy, .rst_out, .rst_oe, .bus_abort, .bus_block, .nv_start_ok,
    .cfg_locked, .wdog_period, .cause
);
`default_nettype wire

// [testbench/ssw_host_model.sv]
// host on the two-wire bus; lines idle high, driven high by the model
// assumes tasks are called from the bench
`timescale 1ns/1ps
`default_nettype none
module ssw_host_model (
    // bus clock
    input  wire logic bus_clock,
    // two-wire lines
    output var  logic scl,
    output var  logic sda
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // data falls while clock high
    task automatic start_cond();
        @(posedge bus_clock) sda <= 1'b0;
        @(posedge bus_clock) scl <= 1'b0;
        @(posedge bus_clock) sda <= 1'b1;
        @(posedge bus_clock) scl <= 1'b1;
    endtask : start_cond
    // data moves only while clock low
    task automatic data_toggle();
        @(posedge bus_clock) scl <= 1'b0;
        @(posedge bus_clock) sda <= 1'b0;
        @(posedge bus_clock) sda <= 1'b1;
        @(posedge bus_clock) scl <= 1'b1;
    endtask : data_toggle
endmodule : ssw_host_model
`default_nettype wire

// [testbench/tb_supply_supervisor_watchdog_reset.sv]
// bench for the supervisor with shortened counts
// assumes the host model drives the two-wire lines
`timescale 1ns/1ps
`default_nettype none
module tb_supply_supervisor_watchdog_reset;
    import ssw_pkg::*;
    localparam int R = 100;
    localparam int LIM [3] = '{200, 300, 400};
    localparam logic [1:0] CODE [3] = '{2'h2, 2'h1, 2'h0};
    logic       clock = 1'b0;
    logic       bus_clock = 1'b0;
    logic       arst_n = 1'b0;
    logic       bus_arst_n = 1'b0;
    logic       supply_low = 1'b0;
    logic       wp_pin = 1'b0;
    logic       cfg_wr = 1'b0;
    ssw_cfg_s   cfg_data = '0;
    logic       nv_busy = 1'b0;
    int         abort_cnt = 0;
    int         a0;
    logic       scl, sda, rst_out, rst_oe, bus_abort, bus_block;
    logic       nv_start_ok, cfg_locked;
    logic [1:0] wdog_period;
    ssw_cause_s cause;
    int         error_cnt = 0;
    int         check_count = 0;
    int         cyc = 0;
    int         t;

    initial begin
        forever #2 clock = ~clock;
    end
    initial begin
        #1.3;
        forever #7.5 bus_clock = ~bus_clock;
    end

    ssw_host_model u_ssw_host_model (.bus_clock, .scl, .sda);
    ssw_supervisor #(.RELEASE_CYCLES(R), .WD_LONG_CYCLES(400),
        .WD_MID_CYCLES(300), .WD_SHORT_CYCLES(200), .ACTIVE_HIGH(1'b0)
    ) u_ssw_supervisor (
        .clock, .arst_n, .bus_clock, .bus_arst_n, .supply_low,
        .scl_in(scl), .sda_in(sda), .wp_pin, .cfg_wr, .cfg_data,
        .nv_busy, .rst_out, .rst_oe, .bus_abort, .bus_block,
        .nv_start_ok, .cfg_locked, .wdog_period, .cause
    );

    always @(posedge bus_clock) begin
        if (bus_abort === 1'b1) begin
            abort_cnt <= abort_cnt + 1;
        end
    end
    // ----------------------------------------------------------
    // helpers
    // ----------------------------------------------------------
    task automatic end_of_test();
        if (error_cnt == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end
    task automatic chk(string what, logic [1:0] exp, logic [1:0] got);
        check_count++;
        if (got !== exp) begin
            $display("[ERR] %s exp %h got %h", what, exp, got);
            error_cnt++;
        end
    endtask : chk
    task automatic wait_oe(input logic lvl, input int n, output int k);
        k = 0;
        while (rst_oe !== lvl && k < n) begin
            @(negedge clock);
            k++;
        end
    endtask : wait_oe
    task automatic cfg_write(input logic [1:0] code, input logic pe);
        @(posedge bus_clock) cfg_wr <= 1'b1;
        cfg_data <= {code, pe};
        @(posedge bus_clock) cfg_wr <= 1'b0;
        repeat (8) @(posedge bus_clock);
        repeat (10) @(negedge clock);
    endtask : cfg_write
    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    task automatic t_power_up();
        wait_oe(1'b0, R + 30, t);
        chk("power-up hold", 2'h1, t >= R && t < R + 30);
        chk("period default", 2'h3, wdog_period);
        repeat (20) @(negedge clock);
        chk("write permit", 2'h1, nv_start_ok);
        chk("bus open", 2'h0, bus_block);
    endtask : t_power_up
    task automatic t_brownout();
        a0 = abort_cnt;
        @(posedge clock) supply_low <= 1'b1;
        wait_oe(1'b1, 10, t);
        chk("low asserts", 2'h1, t < 10);
        repeat (20) @(negedge clock);
        chk("low cause", 2'h1, cause.supply_low);
        chk("abort pulse", 2'h1, abort_cnt != a0);
        chk("bus blocked", 2'h1, bus_block);
        cfg_write(2'h2, 1'b0);
        chk("write in reset", 2'h3, wdog_period);
        @(posedge clock) supply_low <= 1'b0;
        wait_oe(1'b0, R + 30, t);
        chk("good hold", 2'h1, t >= R && t < R + 30);
    endtask : t_brownout
    task automatic t_timeouts();
        for (int i = 0; i < 3; i++) begin
            cfg_write(CODE[i], 1'b0);
            chk("period code", CODE[i], wdog_period);
            a0 = abort_cnt;
            u_ssw_host_model.start_cond();
            wait_oe(1'b1, LIM[i] + 60, t);
            chk("timeout", 2'h1, t + 30 >= LIM[i] && t < LIM[i] + 40);
            repeat (20) @(negedge clock);
            chk("timeout cause", 2'h1, cause.wdog_expired);
            chk("timeout abort", 2'h1, abort_cnt != a0);
            wait_oe(1'b0, R + 40, t);
        end
    endtask : t_timeouts
    task automatic t_keepalive();
        cfg_write(2'h2, 1'b0);
        @(posedge clock) nv_busy <= 1'b1;
        repeat (5) begin
            u_ssw_host_model.start_cond();
            wait_oe(1'b1, 120, t);
            chk("kept alive", 2'h1, t == 120);
        end
        chk("busy gate", 2'h0, nv_start_ok);
        @(posedge clock) nv_busy <= 1'b0;
        u_ssw_host_model.data_toggle();
        u_ssw_host_model.data_toggle();
        wait_oe(1'b1, 100, t);
        chk("toggle ignored", 2'h1, t < 100);
        wait_oe(1'b0, R + 40, t);
        cfg_write(2'h3, 1'b0);
        wait_oe(1'b1, 600, t);
        chk("disabled", 2'h1, t == 600);
    endtask : t_keepalive
    task automatic t_lock();
        @(posedge clock) wp_pin <= 1'b1;
        cfg_write(2'h3, 1'b1);
        chk("locked", 2'h1, cfg_locked);
        cfg_write(2'h1, 1'b1);
        chk("locked period", 2'h3, wdog_period);
        @(posedge clock) wp_pin <= 1'b0;
        repeat (10) @(negedge clock);
        chk("unlocked", 2'h0, cfg_locked);
    endtask : t_lock

    initial begin
        repeat (6) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge bus_clock) bus_arst_n <= 1'b1;
        t_power_up();
        t_brownout();
        t_timeouts();
        t_keepalive();
        t_lock();
        end_of_test();
    end
endmodule : tb_supply_supervisor_watchdog_reset
`default_nettype wire
